// [rtl/qbg_pkg.sv]
package qbg_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam int         ADDR_W         = 6;
  localparam logic [5:0] OFS_OUT_TEN    = 6'h00;
  localparam logic [5:0] OFS_OUT_D      = 6'h04;
  localparam logic [5:0] OFS_OUT_C      = 6'h08;
  localparam logic [5:0] OFS_PIN_TEN    = 6'h0C;
  localparam logic [5:0] OFS_PIN_D      = 6'h10;
  localparam logic [5:0] OFS_PIN_C      = 6'h14;
  localparam logic [5:0] OFS_STATUS     = 6'h18;
  localparam logic [5:0] OFS_MASK       = 6'h1C;
  localparam logic [5:0] OFS_CTRL       = 6'h20;

  // ********************************************************
  // Reset values and field positions
  // ********************************************************
  localparam logic [7:0] OUT_RST        = 8'hFF;
  localparam logic [7:0] PIN_RST        = 8'hFF;
  localparam logic [7:0] MASK_RST       = 8'h00;
  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] CTRL_RST       = 8'h00;
  localparam logic [7:0] DRIVE_DEF      = 8'hFF;
  localparam int         CTRL_TX_EN     = 0;
  localparam int         UART_RX_BIT    = 1;
  localparam int         UART_TX_BIT    = 0;
  localparam int         WAKE_LSB       = 2;
  localparam int         WAKE_W         = 6;
  localparam int         EXT_LSB        = 0;
  localparam int         EXT_W          = 2;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic [7:0] port_ten_pins;
    logic [7:0] port_d_pins;
    logic [7:0] port_c_pins;
  } qbg_pads_t;

endpackage

// [rtl/qbg_gpio.sv]
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - While the active-low chip reset pin is low the whole block is held in reset, by level.
// - Each of the three ports is eight bits wide and each bit serves as input or output.
// - A per-bit build option picks push-pull drive for 1 and open-drain drive for 0.
// - An open-drain pad whose latch bit is 1 is released by the block; otherwise it is driven from the latch and drive type.
// - Port D bits 7 to 2 raise wake-up events that bring the chip out of low power.
// - Port D bits 7 and 6 raise external interrupt requests to the processor.
// - Port D bit 1 carries the UART receive input from its pad.
// - Port D bit 0 can carry the UART transmit output onto its pad.
module qbg_gpio #(
  parameter logic [7:0] PORT_TEN_DRIVE_TYPE_OPTION = qbg_pkg::DRIVE_DEF,
  parameter logic [7:0] PORT_D_DRIVE_TYPE_OPTION   = qbg_pkg::DRIVE_DEF,
  parameter logic [7:0] PORT_C_DRIVE_TYPE_OPTION   = qbg_pkg::DRIVE_DEF
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        chip_reset_n_pin,
  input  wire qbg_pkg::qbg_pads_t          pad_in,
  output var  qbg_pkg::qbg_pads_t          pad_out,
  output var  qbg_pkg::qbg_pads_t          pad_oe,
  input  wire logic                        uart_tx_pad,
  output logic                             uart_rx_pad,
  output logic                             wake_req,
  output logic [1:0]                       ext_int_req,
  output logic                             irq,
  output logic                             chip_reset,
  input  wire logic [qbg_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [qbg_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import qbg_pkg::*;
  localparam qbg_pads_t DRV = {PORT_TEN_DRIVE_TYPE_OPTION,
                               PORT_D_DRIVE_TYPE_OPTION,
                               PORT_C_DRIVE_TYPE_OPTION};

  // ********************************************************
  // Reset and pin synchronisers
  // ********************************************************
  logic      rstn_s1_ff;
  logic      rstn_s2_ff;
  logic      srst;
  qbg_pads_t pin_s1_ff;
  qbg_pads_t pin_s2_ff;
  qbg_pads_t pin_prv_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rstn_s1_ff <= 1'b0;
      rstn_s2_ff <= 1'b0;
    end else begin
      rstn_s1_ff <= chip_reset_n_pin;
      rstn_s2_ff <= rstn_s1_ff;
    end
  end
  // The internal reset follows the pin level, not an edge of it.
  assign srst       = rst | ~rstn_s2_ff;
  assign chip_reset = srst;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_s1_ff  <= {3{PIN_RST}};
      pin_s2_ff  <= {3{PIN_RST}};
      pin_prv_ff <= {3{PIN_RST}};
    end else begin
      pin_s1_ff  <= pad_in;
      pin_s2_ff  <= pin_s1_ff;
      pin_prv_ff <= pin_s2_ff;
    end
  end
  assign uart_rx_pad = pin_s2_ff.port_d_pins[UART_RX_BIT];

  // ********************************************************
  // Bus write channel
  // ********************************************************
  logic              aw_hold_ff;
  logic              nxt_aw_hold;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [ADDR_W-1:0] nxt_awaddr;
  logic              w_hold_ff;
  logic              nxt_w_hold;
  logic [7:0]        wdata_ff;
  logic [7:0]        nxt_wdata;
  logic              wlane_ff;
  logic              nxt_wlane;
  logic              bvalid_ff;
  logic              nxt_bvalid;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic              do_wr;
  logic              wr_hit;
  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign do_wr         = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_hit        = (awaddr_ff <= OFS_CTRL) && (awaddr_ff[1:0] == 2'h0);
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_wdata   = wdata_ff;
    nxt_wlane   = wlane_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_hold = 1'b1;
      nxt_wdata  = s_axi_wdata[7:0];
      nxt_wlane  = s_axi_wstrb[0];
    end
    if (do_wr) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff  <= '0;
      w_hold_ff  <= 1'b0;
      wdata_ff   <= '0;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      awaddr_ff  <= nxt_awaddr;
      w_hold_ff  <= nxt_w_hold;
      wdata_ff   <= nxt_wdata;
      wlane_ff   <= nxt_wlane;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  // ********************************************************
  // Registers and events
  // ********************************************************
  qbg_pads_t  out_ff;
  qbg_pads_t  nxt_out;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] fall;
  logic [7:0] events;
  logic       wr_en;
  assign wr_en  = do_wr & wlane_ff;
  assign fall   = pin_prv_ff.port_d_pins & ~pin_s2_ff.port_d_pins;
  assign events = {fall[7:WAKE_LSB], fall[7:6]};
  always_comb begin
    nxt_out    = out_ff;
    nxt_mask   = mask_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_status = status_ff;
    if (wr_en) begin
      case (awaddr_ff)
        OFS_OUT_TEN: nxt_out.port_ten_pins = wdata_ff;
        OFS_OUT_D:   nxt_out.port_d_pins   = wdata_ff;
        OFS_OUT_C:   nxt_out.port_c_pins   = wdata_ff;
        OFS_MASK:    nxt_mask              = wdata_ff;
        OFS_CTRL:    nxt_ctrl              = {7'h00, wdata_ff[CTRL_TX_EN]};
        OFS_STATUS:  nxt_status            = status_ff & ~wdata_ff;
        default:     nxt_out               = out_ff;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    nxt_status = nxt_status | events;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_ff    <= {3{OUT_RST}};
      mask_ff   <= MASK_RST;
      ctrl_ff   <= CTRL_RST;
      status_ff <= STATUS_RST;
    end else begin
      out_ff    <= nxt_out;
      mask_ff   <= nxt_mask;
      ctrl_ff   <= nxt_ctrl;
      status_ff <= nxt_status;
    end
  end
  assign wake_req    = |(status_ff[WAKE_LSB +: WAKE_W] & mask_ff[WAKE_LSB +: WAKE_W]);
  assign ext_int_req = status_ff[EXT_LSB +: EXT_W] & mask_ff[EXT_LSB +: EXT_W];
  assign irq         = |(status_ff & mask_ff);

  // ********************************************************
  // Pad drivers
  // ********************************************************
  qbg_pads_t lat;
  qbg_pads_t pad_out_ff;
  qbg_pads_t pad_oe_ff;
  qbg_pads_t nxt_pad_out;
  qbg_pads_t nxt_pad_oe;
  always_comb begin
    lat = out_ff;
    if (ctrl_ff[CTRL_TX_EN]) begin
      lat.port_d_pins[UART_TX_BIT] = uart_tx_pad;
    end
    // Push-pull drives the latch; open-drain pulls low only.
    nxt_pad_out = lat & DRV;
    nxt_pad_oe  = DRV | ~lat;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pad_out_ff <= {3{OUT_RST}} & DRV;
      pad_oe_ff  <= DRV | ~{3{OUT_RST}};
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff  <= nxt_pad_oe;
    end
  end
  assign pad_out = pad_out_ff;
  assign pad_oe  = pad_oe_ff;

  // ********************************************************
  // Bus read channel
  // ********************************************************
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0]  rresp_ff;
  logic [1:0]  nxt_rresp;
  logic [7:0]  rd_val;
  logic        rd_hit;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_OUT_TEN: rd_val = out_ff.port_ten_pins;
      OFS_OUT_D:   rd_val = out_ff.port_d_pins;
      OFS_OUT_C:   rd_val = out_ff.port_c_pins;
      OFS_PIN_TEN: rd_val = pin_s2_ff.port_ten_pins;
      OFS_PIN_D:   rd_val = pin_s2_ff.port_d_pins;
      OFS_PIN_C:   rd_val = pin_s2_ff.port_c_pins;
      OFS_STATUS:  rd_val = status_ff;
      OFS_MASK:    rd_val = mask_ff;
      OFS_CTRL:    rd_val = ctrl_ff;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = {24'h000000, rd_val};
      nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  sequence pin_low_s;
    !rstn_s2_ff;
  endsequence
  sequence out_ten_wr_s;
    wr_en && (awaddr_ff == OFS_OUT_TEN);
  endsequence
  reset_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    pin_low_s |=> (status_ff == STATUS_RST) && (out_ff == {3{OUT_RST}}) && !s_axi_bvalid)
    else $error("block not held in reset while reset pin low");
  latch_write_a: assert property (@(posedge core_clk) disable iff (srst)
    out_ten_wr_s |=> (out_ff.port_ten_pins == $past(wdata_ff)))
    else $error("port ten latch not updated by write");
  push_pull_a: assert property (@(posedge core_clk) disable iff (srst)
    ((pad_oe & DRV) == DRV) && ((pad_out & DRV) == ($past(lat) & DRV)))
    else $error("push-pull bit not driving its latch");
  open_drain_a: assert property (@(posedge core_clk) disable iff (srst)
    ((pad_oe & ~DRV) == (~$past(lat) & ~DRV)) && ((pad_out & ~DRV) == '0))
    else $error("open-drain bit drive wrong");
  wake_event_a: assert property (@(posedge core_clk) disable iff (srst)
    (pin_prv_ff.port_d_pins[2] && !pin_s2_ff.port_d_pins[2]) |=> status_ff[2])
    else $error("wake event lost");
  ext_int_a: assert property (@(posedge core_clk) disable iff (srst)
    (pin_prv_ff.port_d_pins[7] && !pin_s2_ff.port_d_pins[7] && mask_ff[1])
      ##1 mask_ff[1] |-> ext_int_req[1] && irq)
    else $error("external interrupt not raised");
  uart_rx_a: assert property (@(posedge core_clk) disable iff (srst)
    (!$past(srst, 2) && !$past(srst)) |-> (uart_rx_pad == $past(pad_in.port_d_pins[1], 2)))
    else $error("uart receive does not follow pad");
  uart_tx_a: assert property (@(posedge core_clk) disable iff (srst)
    (ctrl_ff[CTRL_TX_EN] && !uart_tx_pad) |=> !pad_out.port_d_pins[0] && pad_oe.port_d_pins[0])
    else $error("uart transmit low not driven onto pad");
  pin_read_a: assert property (@(posedge core_clk) disable iff (srst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_PIN_C)
      |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(pin_s2_ff.port_c_pins)))
    else $error("pin read returns wrong level");
endmodule

`default_nettype wire

// [rtl/placeholder_none.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [sim/qbg_board.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Board side of the port pads
// ****************************************
module qbg_board
  import qbg_pkg::*;
(
  input  wire qbg_pkg::qbg_pads_t ext_level,
  input  wire qbg_pkg::qbg_pads_t pad_out,
  input  wire qbg_pkg::qbg_pads_t pad_oe,
  output var  qbg_pkg::qbg_pads_t pad_level
);
  // A released pad follows the board, which idles high through its pull-up.
  assign pad_level = qbg_pads_t'((pad_oe & pad_out) | (~pad_oe & ext_level));
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port block bench
// ****************************************
module tb_top;
  import qbg_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        chip_reset_n_pin = 1'b1;
  logic        uart_tx_pad = 1'b1;
  qbg_pads_t   ext_level = 24'hFFFFFF;
  qbg_pads_t   pad_level;
  qbg_pads_t   pad_out;
  qbg_pads_t   pad_oe;
  logic        uart_rx_pad;
  logic        wake_req;
  logic [1:0]  ext_int_req;
  logic        irq;
  logic        chip_reset;
  logic [5:0]  awaddr = 6'h00;
  logic [5:0]  araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  int          mismatches = 0;
  int          tests_run = 0;
  logic [5:0]  out_ofs [3];
  logic [5:0]  pin_ofs [3];
  logic [7:0]  drv [3];
  logic [7:0]  p;
  logic [7:0]  oe_x;
  logic [7:0]  st_x;

  always #25 core_clk = ~core_clk;

  qbg_board board (.ext_level(ext_level), .pad_out(pad_out), .pad_oe(pad_oe),
                   .pad_level(pad_level));

  qbg_gpio #(.PORT_TEN_DRIVE_TYPE_OPTION(8'hFF), .PORT_D_DRIVE_TYPE_OPTION(8'h00),
             .PORT_C_DRIVE_TYPE_OPTION(8'h0F)) uut (
    .core_clk(core_clk), .rst(rst), .chip_reset_n_pin(chip_reset_n_pin),
    .pad_in(pad_level), .pad_out(pad_out), .pad_oe(pad_oe), .uart_tx_pad(uart_tx_pad),
    .uart_rx_pad(uart_rx_pad), .wake_req(wake_req), .ext_int_req(ext_int_req), .irq(irq),
    .chip_reset(chip_reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Ready is combinational, so it is sampled mid-cycle where it has settled.
  task automatic wchk(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw_t;
    logic w_t;
    logic b_t;
    logic [1:0] r;
    n = 0;
    b_t = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge core_clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
      if (n > 40) begin
        mismatches++;
        complete_run();
      end
    end
    bready <= 1'b0;
    chk(r, er);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    logic ar_t;
    logic r_t;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    r_t = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge core_clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ar_t) arvalid <= 1'b0;
      n++;
      if (n > 40) begin
        mismatches++;
        complete_run();
      end
    end
    rready <= 1'b0;
    chk(d, {24'h0, ed});
    chk(r, er);
  endtask

  initial begin
    out_ofs = '{OFS_OUT_TEN, OFS_OUT_D, OFS_OUT_C};
    pin_ofs = '{OFS_PIN_TEN, OFS_PIN_D, OFS_PIN_C};
    drv = '{8'hFF, 8'h00, 8'h0F};
    cyc(12);
    rst <= 1'b0;
    cyc(3);
    for (int i = 0; i < 3; i++) rchk(out_ofs[i], 8'hFF, RESP_OKAY);
    rchk(OFS_STATUS, 8'h00, RESP_OKAY);
    rchk(OFS_MASK, 8'h00, RESP_OKAY);
    rchk(OFS_CTRL, 8'h00, RESP_OKAY);
    $display("test reset_values done");
    ext_level <= 24'h3C3C3C;
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 2; j++) begin
        p = j ? 8'hA5 : 8'h5A;
        wchk(out_ofs[i], p, RESP_OKAY);
        cyc(4);
        oe_x = drv[i] | ~p;
        chk(pad_oe[23-8*i -: 8], oe_x);
        chk(pad_out[23-8*i -: 8], p & drv[i]);
        rchk(pin_ofs[i], (oe_x & p & drv[i]) | (~oe_x & 8'h3C), RESP_OKAY);
        rchk(out_ofs[i], p, RESP_OKAY);
      end
      wchk(out_ofs[i], 8'hFF, RESP_OKAY);
    end
    ext_level <= 24'hFFFFFF;
    wchk(OFS_PIN_TEN, 8'h00, RESP_OKAY);
    rchk(OFS_PIN_TEN, 8'hFF, RESP_OKAY);
    rchk(6'h24, 8'h00, RESP_SLVERR);
    wchk(6'h24, 8'h55, RESP_SLVERR);
    $display("test drive_types done");
    wchk(OFS_MASK, 8'hFF, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      ext_level.port_d_pins <= 8'hFF;
      cyc(6);
      wchk(OFS_STATUS, 8'hFF, RESP_OKAY);
      ext_level.port_d_pins[k] <= 1'b0;
      cyc(6);
      st_x = (k >= 2) ? (8'h01 << k) : 8'h00;
      st_x[1] = (k == 7);
      st_x[0] = (k == 6);
      rchk(OFS_STATUS, st_x, RESP_OKAY);
      chk({irq, wake_req, ext_int_req}, {st_x != 8'h00, |st_x[7:2], st_x[1:0]});
      chk(uart_rx_pad, k != 1);
    end
    wchk(OFS_MASK, 8'h7D, RESP_OKAY);
    chk({irq, wake_req, ext_int_req}, 4'h0);
    wchk(OFS_STATUS, 8'h82, RESP_OKAY);
    rchk(OFS_STATUS, 8'h00, RESP_OKAY);
    $display("test wake_and_interrupt done");
    ext_level.port_d_pins <= 8'hFF;
    wchk(OFS_CTRL, 8'h01, RESP_OKAY);
    for (int j = 0; j < 4; j++) begin
      uart_tx_pad <= j[0];
      cyc(3);
      chk(pad_level.port_d_pins[0], j[0]);
    end
    wchk(OFS_CTRL, 8'h00, RESP_OKAY);
    uart_tx_pad <= 1'b0;
    cyc(3);
    chk(pad_level.port_d_pins[0], 1'b1);
    $display("test uart_pads done");
    wchk(OFS_OUT_TEN, 8'h00, RESP_OKAY);
    chip_reset_n_pin <= 1'b0;
    cyc(8);
    chk(chip_reset, 1'b1);
    chk(pad_out.port_ten_pins, 8'hFF);
    chip_reset_n_pin <= 1'b1;
    cyc(4);
    chk(chip_reset, 1'b0);
    rchk(OFS_OUT_TEN, 8'hFF, RESP_OKAY);
    $display("test reset_pin done");
    complete_run();
  end
endmodule
`default_nettype wire
